// ---- common/ptcc_pkg.sv ----
// Purpose: shared constants and types for the transmit command control block
// Assumes: 50 MHz reference clock, 32-bit APB data, one register per aligned word
// Notes:   register indices are word indices; byte address is four times the index
package ptcc_pkg;

   // register indices and bus geometry
   localparam int unsigned ADDR_W   = 16;
   localparam logic [13:0] CTL_IDX  = 14'h1a05;
   localparam logic [13:0] STAT_IDX = 14'h1a10;
   localparam logic [13:0] MASK_IDX = 14'h1a11;
   localparam logic [13:0] PCTL_IDX = 14'h1a12;

   // command control field positions
   localparam int GO_BIT    = 0;
   localparam int ABORT_BIT = 1;
   localparam int HARD_BIT  = 2;
   localparam int QRST_BIT  = 3;
   localparam int IDLE_BIT  = 4;
   localparam int CABLE_BIT = 5;

   // interrupt status / mask and primary control fields
   localparam int IRQ_W        = 2;
   localparam int IRQ_EOP_BIT  = 0;
   localparam int IRQ_COLL_BIT = 1;
   localparam int RAW_BIT      = 0;

   // reset values
   localparam logic             CMD_RST  = 1'b0;
   localparam logic             IDLE_RST = 1'b1;
   localparam logic             RAW_RST  = 1'b0;
   localparam logic [IRQ_W-1:0] IRQ_RST  = 2'h0;

   // timing: bit time from clock and nominal bit rate
   localparam int unsigned CLK_KHZ       = 50000;
   localparam int unsigned BIT_RATE_KBPS = 300;
   localparam int unsigned BIT_CYCLES    = CLK_KHZ / BIT_RATE_KBPS;
   localparam int unsigned PREAMBLE_BITS = 64;
   localparam int unsigned SYM_BITS      = 5;
   localparam int unsigned RST_SYMS      = 4;
   localparam int unsigned LEN_W         = 7;

   typedef enum logic [1:0] {
      PTCC_KIND_PKT,
      PTCC_KIND_HARD,
      PTCC_KIND_CABLE
   } ptcc_kind_t;

   typedef enum logic [1:0] {
      PTCC_PH_IDLE,
      PTCC_PH_PRE,
      PTCC_PH_DATA,
      PTCC_PH_EOP
   } ptcc_phase_t;

   typedef struct packed {
      ptcc_kind_t       kind;
      logic [LEN_W-1:0] len;
   } ptcc_req_t;

endpackage : ptcc_pkg

// ---- hw/ptcc_tx_seq.sv ----
// Purpose: frame sequencer: preamble, symbols, end-of-packet
// Assumes: start only while idle; stop is a one-cycle pulse
// Notes:   a stop is honoured at the next preamble end or symbol boundary
`timescale 1ns/1ns
module ptcc_tx_seq #(
   parameter int unsigned BIT_CYC  = ptcc_pkg::BIT_CYCLES,
   parameter int unsigned PRE_BITS = ptcc_pkg::PREAMBLE_BITS
) (
   // clock and reset
   input  wire logic              clk,
   input  wire logic              rst_b,
   // control
   input  wire logic              start,
   input  ptcc_pkg::ptcc_req_t    req,
   input  wire logic              stop,
   // state
   output ptcc_pkg::ptcc_phase_t  phase,
   output logic                   done
);
   import ptcc_pkg::*;

   localparam int TW = $clog2(BIT_CYC + 1);

   ptcc_phase_t    phase_q;
   logic [TW-1:0]  tick_q;
   logic [6:0]     bit_q;
   logic [7:0]     sym_q;
   logic [7:0]     nsym_q;
   logic           stop_q;
   logic           bit_end;
   logic           pre_end;
   logic           sym_end;

   assign bit_end = (tick_q == TW'(BIT_CYC - 1));
   assign pre_end = bit_end && (bit_q == 7'(PRE_BITS - 1));
   assign sym_end = bit_end && (bit_q == 7'(SYM_BITS - 1));
   assign phase   = phase_q;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         phase_q <= PTCC_PH_IDLE;
      end else begin
         unique case (phase_q)
            PTCC_PH_IDLE: if (start) phase_q <= PTCC_PH_PRE;
            // preamble always runs to its end, even when stopped
            PTCC_PH_PRE:  if (pre_end) phase_q <= stop_q ? PTCC_PH_EOP : PTCC_PH_DATA;
            PTCC_PH_DATA: if (sym_end && (stop_q || sym_q == nsym_q - 8'h01))
                             phase_q <= PTCC_PH_EOP;
            PTCC_PH_EOP:  if (sym_end) phase_q <= PTCC_PH_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         tick_q <= '0;
         bit_q  <= 7'h00;
      end else if (phase_q == PTCC_PH_IDLE) begin
         tick_q <= '0;
         bit_q  <= 7'h00;
      end else if (bit_end) begin
         tick_q <= '0;
         bit_q  <= (phase_q == PTCC_PH_PRE ? pre_end : sym_end) ? 7'h00 : bit_q + 7'h01;
      end else begin
         tick_q <= tick_q + TW'(1);
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sym_q  <= 8'h00;
         nsym_q <= 8'h00;
      end else if (start && phase_q == PTCC_PH_IDLE) begin
         sym_q  <= 8'h00;
         // reset signalling ignores the queued length
         nsym_q <= (req.kind == PTCC_KIND_PKT) ? {req.len, 1'b0} : 8'(RST_SYMS);
      end else if (phase_q == PTCC_PH_DATA && sym_end) begin
         sym_q  <= sym_q + 8'h01;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         stop_q <= 1'b0;
         done   <= 1'b0;
      end else begin
         stop_q <= (phase_q == PTCC_PH_IDLE) ? 1'b0 : (stop_q | stop);
         done   <= (phase_q == PTCC_PH_EOP) && sym_end;
      end
   end

endmodule : ptcc_tx_seq

// ---- hw/ptcc_top.sv ----
// Purpose: transmit command control register with launch, reset requests and abort
// Assumes: line busy and auto-response inputs come from logic on REF_CLK
// Notes:   collision input is a pin and is synchronised before use
//
// The APB register port is this design's own decision.
`timescale 1ns/1ns
module ptcc_top (
   // clock and reset
   input  wire logic                         REF_CLK,
   input  wire logic                         RST_B,
   // apb slave
   input  wire logic                         PSEL,
   input  wire logic                         PENABLE,
   input  wire logic                         PWRITE,
   input  wire logic [ptcc_pkg::ADDR_W-1:0]  PADDR,
   input  wire logic [31:0]                  PWDATA,
   output logic      [31:0]                  PRDATA,
   output logic                              PREADY,
   output logic                              PSLVERR,
   // line and receive side status
   input  wire logic                         LINE_BUSY,
   input  wire logic                         AUTO_RSP_BUSY,
   input  wire logic                         COLLISION,
   input  wire logic [ptcc_pkg::LEN_W-1:0]   QUEUE_LEN,
   // transmit side
   output ptcc_pkg::ptcc_phase_t             TX_PHASE,
   output ptcc_pkg::ptcc_kind_t              TX_KIND,
   output logic                              QUEUE_PTR_RST,
   // interrupt
   output logic                              IRQ
);
   import ptcc_pkg::*;

   localparam int ABORT_MAX = 840;

   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [13:0] idx);
      hit = (a == {idx, 2'b00});
   endfunction : hit

   logic              go_q;
   logic              hard_q;
   logic              cable_q;
   logic              idle_q;
   logic              raw_q;
   logic              start_q;
   logic              stop_q;
   logic              coll_s1_q;
   logic              coll_s2_q;
   logic              done;
   logic              busy;
   logic              wr;
   logic              ctl_wr;
   logic              setup_rd;
   logic              launch;
   logic              hard_now;
   logic              cable_now;
   logic              coll_ev;
   logic [IRQ_W-1:0]  stat_q;
   logic [IRQ_W-1:0]  stat_d;
   logic [IRQ_W-1:0]  mask_q;
   logic [31:0]       rd_d;
   logic              map_hit;
   ptcc_req_t         req_q;
   ptcc_phase_t       phase;

   assign wr       = PSEL && PENABLE && PWRITE && PREADY;
   assign ctl_wr   = wr && hit(PADDR, CTL_IDX);
   assign setup_rd = PSEL && !PENABLE;
   assign launch   = ctl_wr && PWDATA[GO_BIT] && !go_q;
   assign busy     = (phase != PTCC_PH_IDLE);
   assign coll_ev  = coll_s2_q && busy;
   assign map_hit  = hit(PADDR, CTL_IDX) || hit(PADDR, STAT_IDX)
                  || hit(PADDR, MASK_IDX) || hit(PADDR, PCTL_IDX);

   // requests seen by this launch, including bits written in the same access
   assign hard_now  = hard_q || (PWDATA[HARD_BIT] && !go_q);
   assign cable_now = !hard_now && (cable_q || (PWDATA[CABLE_BIT] && !go_q));

   // collision pin: two flops before any logic
   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         coll_s1_q <= 1'b0;
         coll_s2_q <= 1'b0;
      end else begin
         coll_s1_q <= COLLISION;
         coll_s2_q <= coll_s1_q;
      end
   end

   // launch bit: set only by a one, cleared only by completion
   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         go_q <= CMD_RST;
      end else if (done) begin
         go_q <= 1'b0;
      end else if (launch) begin
         go_q <= 1'b1;
      end
   end

   // reset requests: stored regardless of mode, the mode decides at launch
   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         hard_q  <= CMD_RST;
         cable_q <= CMD_RST;
      end else if (done) begin
         hard_q  <= 1'b0;
         cable_q <= 1'b0;
      end else if (ctl_wr && !go_q) begin
         hard_q  <= hard_q | PWDATA[HARD_BIT];
         cable_q <= cable_q | (PWDATA[CABLE_BIT] & ~PWDATA[HARD_BIT]);
      end
   end

   // launch request toward the sequencer
   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         start_q <= 1'b0;
         req_q   <= '{kind: PTCC_KIND_PKT, len: '0};
      end else begin
         start_q <= launch;
         if (launch) begin
            req_q.len <= QUEUE_LEN;
            if (raw_q) begin
               req_q.kind <= PTCC_KIND_PKT;
            end else if (hard_now) begin
               req_q.kind <= PTCC_KIND_HARD;
            end else if (cable_now) begin
               req_q.kind <= PTCC_KIND_CABLE;
            end else begin
               req_q.kind <= PTCC_KIND_PKT;
            end
         end
      end
   end

   // abort: a pulse only, nothing is stored for readback
   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         stop_q <= 1'b0;
      end else begin
         stop_q <= (ctl_wr && PWDATA[ABORT_BIT]) || coll_ev;
      end
   end

   // queue pointer reset on request, and again once the frame is done
   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         QUEUE_PTR_RST <= 1'b0;
      end else begin
         QUEUE_PTR_RST <= (ctl_wr && PWDATA[QRST_BIT]) || done;
      end
   end

   // line idle, one cycle behind the timer and responder
   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         idle_q <= IDLE_RST;
      end else begin
         idle_q <= !(LINE_BUSY || AUTO_RSP_BUSY);
      end
   end

   // primary control and mask
   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         raw_q  <= RAW_RST;
         mask_q <= IRQ_RST;
      end else if (wr) begin
         if (hit(PADDR, PCTL_IDX)) raw_q <= PWDATA[RAW_BIT];
         if (hit(PADDR, MASK_IDX)) mask_q <= PWDATA[IRQ_W-1:0];
      end
   end

   // sticky status; a same-cycle event beats the write-one clear
   always_comb begin
      stat_d = stat_q;
      if (wr && hit(PADDR, STAT_IDX)) stat_d = stat_d & ~PWDATA[IRQ_W-1:0];
      if (done) stat_d[IRQ_EOP_BIT] = 1'b1;
      if (coll_ev) stat_d[IRQ_COLL_BIT] = 1'b1;
   end

   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         stat_q <= IRQ_RST;
         IRQ    <= 1'b0;
      end else begin
         stat_q <= stat_d;
         IRQ    <= |(stat_d & mask_q);
      end
   end

   // read data assembled in setup so that the answer is ready in access
   always_comb begin
      rd_d = 32'h0000_0000;
      if (hit(PADDR, CTL_IDX)) begin
         rd_d[GO_BIT]    = go_q;
         rd_d[HARD_BIT]  = hard_q;
         rd_d[IDLE_BIT]  = idle_q;
         rd_d[CABLE_BIT] = cable_q;
      end else if (hit(PADDR, STAT_IDX)) begin
         rd_d[IRQ_W-1:0] = stat_q;
      end else if (hit(PADDR, MASK_IDX)) begin
         rd_d[IRQ_W-1:0] = mask_q;
      end else if (hit(PADDR, PCTL_IDX)) begin
         rd_d[RAW_BIT] = raw_q;
      end
   end

   // zero wait state answer; unmapped addresses give slverr
   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         PREADY  <= 1'b0;
         PSLVERR <= 1'b0;
         PRDATA  <= 32'h0000_0000;
      end else begin
         PREADY  <= setup_rd;
         PSLVERR <= setup_rd && !map_hit;
         if (setup_rd) PRDATA <= PWRITE ? 32'h0000_0000 : rd_d;
      end
   end

   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         TX_PHASE <= PTCC_PH_IDLE;
         TX_KIND  <= PTCC_KIND_PKT;
      end else begin
         TX_PHASE <= phase;
         TX_KIND  <= req_q.kind;
      end
   end

   ptcc_tx_seq #(
      .BIT_CYC  (BIT_CYCLES),
      .PRE_BITS (PREAMBLE_BITS)
   ) u_seq (
      .clk   (REF_CLK),
      .rst_b (RST_B),
      .start (start_q),
      .req   (req_q),
      .stop  (stop_q),
      .phase (phase),
      .done  (done)
   );

   // checks
   property p_cable_auto;
      @(posedge REF_CLK) disable iff (!RST_B)
      launch && !raw_q && !hard_q && !PWDATA[HARD_BIT] && PWDATA[CABLE_BIT]
         |=> req_q.kind == PTCC_KIND_CABLE ##1 phase == PTCC_PH_PRE;
   endproperty
   a_cable_auto: assert property (p_cable_auto) else $error("cable reset not launched");

   property p_raw_ignores;
      @(posedge REF_CLK) disable iff (!RST_B)
      launch && raw_q |=> req_q.kind == PTCC_KIND_PKT;
   endproperty
   a_raw_ignores: assert property (p_raw_ignores) else $error("raw mode sent reset");

   property p_busy_blocks;
      @(posedge REF_CLK) disable iff (!RST_B)
      ctl_wr && go_q && !done |=> hard_q == $past(hard_q) && cable_q == $past(cable_q);
   endproperty
   a_busy_blocks: assert property (p_busy_blocks) else $error("request set while busy");

   property p_hard_wins;
      @(posedge REF_CLK) disable iff (!RST_B)
      ctl_wr && !go_q && !done && PWDATA[HARD_BIT] && PWDATA[CABLE_BIT] && !cable_q
         |=> hard_q && !cable_q;
   endproperty
   a_hard_wins: assert property (p_hard_wins) else $error("cable set with hard");

   property p_done_clears;
      @(posedge REF_CLK) disable iff (!RST_B)
      done |=> !go_q && !hard_q && !cable_q && QUEUE_PTR_RST;
   endproperty
   a_done_clears: assert property (p_done_clears) else $error("bits kept after done");

   property p_idle;
      @(posedge REF_CLK) disable iff (!RST_B)
      (LINE_BUSY || AUTO_RSP_BUSY) |=> !idle_q;
   endproperty
   a_idle: assert property (p_idle) else $error("line idle while busy");

   property p_readback;
      @(posedge REF_CLK) disable iff (!RST_B)
      setup_rd && !PWRITE && hit(PADDR, CTL_IDX)
         |=> PRDATA[7:6] == 2'b00 && !PRDATA[QRST_BIT] && !PRDATA[ABORT_BIT]
             && PRDATA[GO_BIT] == $past(go_q);
   endproperty
   a_readback: assert property (p_readback) else $error("write-only bit read back");

   property p_abort_eop;
      @(posedge REF_CLK) disable iff (!RST_B)
      stop_q && phase == PTCC_PH_DATA |-> ##[1:ABORT_MAX] phase == PTCC_PH_EOP;
   endproperty
   a_abort_eop: assert property (p_abort_eop) else $error("abort not ended by eop");

   property p_launch;
      @(posedge REF_CLK) disable iff (!RST_B)
      launch |=> go_q && start_q ##1 phase == PTCC_PH_PRE;
   endproperty
   a_launch: assert property (p_launch) else $error("launch did not start");

   property p_coll;
      @(posedge REF_CLK) disable iff (!RST_B)
      coll_ev |=> stat_q[IRQ_COLL_BIT] && stop_q && (IRQ || !$past(mask_q[IRQ_COLL_BIT]));
   endproperty
   a_coll: assert property (p_coll) else $error("collision not flagged");

   c_hard: cover property (@(posedge REF_CLK) disable iff (!RST_B)
      start_q && req_q.kind == PTCC_KIND_HARD);
   c_abort_pre: cover property (@(posedge REF_CLK) disable iff (!RST_B)
      stop_q && phase == PTCC_PH_PRE);
   c_coll_irq: cover property (@(posedge REF_CLK) disable iff (!RST_B)
      coll_ev ##1 IRQ);

endmodule : ptcc_top

// ---- verification/ptcc_line_model.sv ----
// Purpose: far-side line model: idle timer, auto-response and collision sources
// Assumes: bench requests change just after a rising edge of clk
// Notes:   a clash only reaches the pin while our own frame is on the wire
`timescale 1ns/1ns
module ptcc_line_model (
   // clock
   input  wire logic            clk,
   // bench requests
   input  wire logic            busy_req,
   input  wire logic            auto_req,
   input  wire logic            coll_req,
   // device side
   input  ptcc_pkg::ptcc_phase_t tx_phase,
   output logic                 line_busy,
   output logic                 auto_busy,
   output logic                 collision
);
   import ptcc_pkg::*;

   initial begin
      line_busy = 1'b0;
      auto_busy = 1'b0;
      collision = 1'b0;
   end

   always @(posedge clk) begin
      line_busy <= busy_req;
      auto_busy <= auto_req;
      // no frame, nothing to collide with
      collision <= coll_req && (tx_phase != PTCC_PH_IDLE);
   end
endmodule : ptcc_line_model

// ---- verification/tb.sv ----
// Purpose: self-checking bench for the transmit command control block
// Assumes: apb slave answers in its own time, full-length frames (no shortening parameter)
// Notes:   the hard-reset abort and the collision land early in the preamble, the raw-mode abort in the first symbol, to keep runs short
`timescale 1ns/1ns
module tb;
   import ptcc_pkg::*;

   localparam logic [31:0] C_GO  = 32'h1 << GO_BIT;
   localparam logic [31:0] C_AB  = 32'h1 << ABORT_BIT;
   localparam logic [31:0] C_HR  = 32'h1 << HARD_BIT;
   localparam logic [31:0] C_QR  = 32'h1 << QRST_BIT;
   localparam logic [31:0] C_IDL = 32'h1 << IDLE_BIT;
   localparam logic [31:0] C_CR  = 32'h1 << CABLE_BIT;

   logic              clk, rst_b, psel, penable, pwrite, err, qrst, irq;
   logic [ADDR_W-1:0] paddr;
   logic [31:0]       pwdata, prdata, rd;
   logic              pready, pslverr, line_busy, auto_busy, collision;
   logic              busy_req, auto_req, coll_req;
   logic [LEN_W-1:0]  qlen;
   ptcc_phase_t       tx_phase;
   ptcc_kind_t        tx_kind;
   int                mismatches, compares, cyc, qpulses, q0, pre_n, dat_n;

   ptcc_top DUT (.REF_CLK(clk), .RST_B(rst_b), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(pslverr), .LINE_BUSY(line_busy), .AUTO_RSP_BUSY(auto_busy),
      .COLLISION(collision), .QUEUE_LEN(qlen), .TX_PHASE(tx_phase), .TX_KIND(tx_kind),
      .QUEUE_PTR_RST(qrst), .IRQ(irq));

   ptcc_line_model u_line (.clk(clk), .busy_req(busy_req), .auto_req(auto_req),
      .coll_req(coll_req), .tx_phase(tx_phase), .line_busy(line_busy),
      .auto_busy(auto_busy), .collision(collision));

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   task stop_test;
      $display("mismatches %0d compares %0d", mismatches, compares);
      if (mismatches == 0 && compares > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : stop_test

   // hang guard: three frames need well under 45k cycles
   always @(posedge clk) begin
      cyc++;
      if (qrst === 1'b1) qpulses++;
      if (tx_phase === PTCC_PH_PRE) pre_n++;
      if (tx_phase === PTCC_PH_DATA) dat_n++;
      if (cyc == 60000) begin
         mismatches++;
         stop_test;
      end
   end

   task chk_reg(input string n, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         mismatches++;
         $display("unexpected %s expected %h seen %h", n, e, g);
      end
   endtask : chk_reg

   task chk_sig(input string n, input logic [3:0] e, input logic [3:0] g);
      compares++;
      if (g !== e) begin
         mismatches++;
         $display("unexpected %s expected %h seen %h", n, e, g);
      end
   endtask : chk_sig

   task apb(input logic w, input logic [13:0] idx, input logic [31:0] d);
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= {idx, 2'b00};
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      // no wait limit here: the bench timeout ends a hang
      while (pready !== 1'b1) @(posedge clk);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task wr(input logic [13:0] idx, input logic [31:0] d);
      apb(1'b1, idx, d);
   endtask : wr

   task rdc(input string n, input logic [13:0] idx, input logic [31:0] e);
      apb(1'b0, idx, 32'h0);
      chk_reg(n, e, rd);
   endtask : rdc

   // frame start then frame end; the bench timeout bounds both waits
   task wait_done;
      while (tx_phase === PTCC_PH_IDLE) @(posedge clk);
      while (tx_phase !== PTCC_PH_IDLE) @(posedge clk);
      repeat (3) @(posedge clk);
   endtask : wait_done

   task t_reset;
      rdc("ctrl", CTL_IDX, C_IDL);
      rdc("stat", STAT_IDX, 32'h0);
      rdc("pctl", PCTL_IDX, 32'h0);
      wr(CTL_IDX, 32'hc0);
      rdc("ctrl rsvd", CTL_IDX, C_IDL);
      apb(1'b0, 14'h0001, 32'h0);
      chk_sig("unmapped err", 4'h1, {3'h0, err});
   endtask : t_reset

   task t_idle;
      busy_req <= 1'b1;
      repeat (3) @(posedge clk);
      rdc("ctrl busy", CTL_IDX, 32'h0);
      busy_req <= 1'b0;
      auto_req <= 1'b1;
      repeat (3) @(posedge clk);
      rdc("ctrl auto", CTL_IDX, 32'h0);
      auto_req <= 1'b0;
      repeat (3) @(posedge clk);
      rdc("ctrl idle", CTL_IDX, C_IDL);
   endtask : t_idle

   task t_hard_abort;
      pre_n = 0;
      dat_n = 0;
      q0 = qpulses;
      wr(CTL_IDX, C_GO | C_HR | C_CR);
      rdc("ctrl go", CTL_IDX, C_IDL | C_GO | C_HR);
      chk_sig("kind", 4'(PTCC_KIND_HARD), 4'(tx_kind));
      wr(CTL_IDX, C_CR);
      wr(CTL_IDX, 32'h0);
      rdc("ctrl pend", CTL_IDX, C_IDL | C_GO | C_HR);
      wr(CTL_IDX, C_AB);
      rdc("ctrl abort", CTL_IDX, C_IDL | C_GO | C_HR);
      wait_done;
      chk_reg("symbols sent", 32'h0, dat_n);
      chk_reg("pre cycles", PREAMBLE_BITS * BIT_CYCLES, pre_n);
      rdc("ctrl end", CTL_IDX, C_IDL);
      rdc("stat eop", STAT_IDX, 32'h1);
      chk_sig("auto ptr rst", 4'h1, 4'(qpulses - q0));
      chk_sig("irq masked", 4'h0, {3'h0, irq});
      wr(MASK_IDX, 32'h1);
      repeat (2) @(posedge clk);
      chk_sig("irq", 4'h1, {3'h0, irq});
      wr(STAT_IDX, 32'h1);
      rdc("stat clr", STAT_IDX, 32'h0);
      chk_sig("irq clr", 4'h0, {3'h0, irq});
   endtask : t_hard_abort

   // abort lands in the first symbol: that symbol ends, then end-of-packet
   task t_raw;
      dat_n = 0;
      wr(PCTL_IDX, 32'h1);
      wr(CTL_IDX, C_GO | C_HR);
      repeat (2) @(posedge clk);
      chk_sig("raw kind", 4'(PTCC_KIND_PKT), 4'(tx_kind));
      while (tx_phase !== PTCC_PH_DATA) @(posedge clk);
      wr(CTL_IDX, C_AB);
      wait_done;
      chk_reg("data cycles", SYM_BITS * BIT_CYCLES, dat_n);
      rdc("ctrl raw end", CTL_IDX, C_IDL);
      wr(PCTL_IDX, 32'h0);
      wr(STAT_IDX, 32'h1);
   endtask : t_raw

   task t_cable_coll;
      pre_n = 0;
      dat_n = 0;
      wr(MASK_IDX, 32'h2);
      wr(CTL_IDX, C_GO | C_CR);
      rdc("ctrl cable", CTL_IDX, C_IDL | C_GO | C_CR);
      chk_sig("cable kind", 4'(PTCC_KIND_CABLE), 4'(tx_kind));
      coll_req <= 1'b1;
      repeat (6) @(posedge clk);
      chk_sig("irq coll", 4'h1, {3'h0, irq});
      coll_req <= 1'b0;
      rdc("stat coll", STAT_IDX, 32'h2);
      wait_done;
      chk_reg("coll symbols", 32'h0, dat_n);
      chk_reg("coll pre cycles", PREAMBLE_BITS * BIT_CYCLES, pre_n);
      rdc("ctrl coll end", CTL_IDX, C_IDL);
      wr(STAT_IDX, 32'h3);
      rdc("stat coll clr", STAT_IDX, 32'h0);
      chk_sig("irq coll clr", 4'h0, {3'h0, irq});
   endtask : t_cable_coll

   task t_qrst;
      q0 = qpulses;
      wr(CTL_IDX, C_QR);
      repeat (2) @(posedge clk);
      chk_sig("ptr rst pulse", 4'h1, 4'(qpulses - q0));
      rdc("ctrl qrst", CTL_IDX, C_IDL);
   endtask : t_qrst

   initial begin
      rst_b = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      busy_req = 1'b0;
      auto_req = 1'b0;
      coll_req = 1'b0;
      qlen = 7'h01;
      repeat (8) @(posedge clk);
      rst_b <= 1'b1;
      t_reset;
      t_idle;
      t_qrst;
      t_hard_abort;
      t_raw;
      t_cable_coll;
      stop_test;
   end
endmodule : tb
